/* logic/serial_rx_consts.svh */
// Register map, field positions, reset values and timing counts of the serial receiver
`ifndef SERIAL_RX_CONSTS_SVH
`define SERIAL_RX_CONSTS_SVH
`define OFF_CTRL        8'h00
`define OFF_MODE        8'h04
`define OFF_TIMEOUT     8'h08
`define OFF_ITEM        8'h0C
`define OFF_STATUS      8'h10
`define OFF_RESULT      8'h14
`define BUF_SEL_BIT     7
`define CTL_START       0
`define CTL_EXT         1
`define CTL_FLOW        2
`define CTL_PAR_EXIT    3
`define CTL_TMO_EN      4
`define CTL_PRESET_LSB  5
`define CTL_BITS_LSB    8
`define CTL_DRIVE       12
`define CTL_MHZ_LSB     24
`define CTRL_RST        32'h0400_0800
`define CTRL_WR_MASK    32'hFF00_1FFE
`define MODE_PAR        13
`define MODE_INV        14
`define ITM_QLEN_LSB    4
`define ITM_CNT_LSB     8
`define ITM_TERM_LSB    16
`define ITM_TERM_EN     24
`define BT_2400         13'h018C
`define BT_1200         13'h032D
`define BT_9600         13'h0054
`define BT_300          13'h0CF1
`define BIT_OFFSET_US   14'h0014
`define TIMEOUT_UNIT_MS 1
`define US_PER_MS       1000
`define TMO_UNIT_US     (`TIMEOUT_UNIT_MS * `US_PER_MS)
`define BUS_LAT         2'h1
`define CHAR_BITS_MIN   4'h4
`define CHAR_BITS_PAR   4'h5
`define CHAR_BITS_MAX   4'h9
`define DATA_BITS_MAX   4'h8
`define STR_LAST        5'h0F
`define ASC_0           8'h30
`define ASC_1           8'h31
`define ASC_9           8'h39
`define ASC_UA          8'h41
`define ASC_UF          8'h46
`define ASC_LA          8'h61
`define ASC_LF          8'h66
`define HEX_LETTER_BIAS 4'h9
`endif

/* logic/serial_rx_pkg.sv */
// Types shared by the serial receiver
`default_nettype none
package serial_rx_pkg;
   typedef enum logic [3:0] {
      F_IDLE  = 4'h1,
      F_START = 4'h2,
      F_BITS  = 4'h4,
      F_STOP  = 4'h8
   } frame_state_t;
   typedef enum logic [2:0] {
      C_IDLE = 3'h1,
      C_QUAL = 3'h2,
      C_ITEM = 3'h4
   } cmd_state_t;
   typedef enum logic [2:0] {
      ITEM_RAW  = 3'h0,
      ITEM_DEC  = 3'h1,
      ITEM_BIN  = 3'h2,
      ITEM_HEX  = 3'h3,
      ITEM_SKIP = 3'h4,
      ITEM_STR  = 3'h5
   } item_kind_t;
endpackage
`default_nettype wire

/* logic/byte_store.sv */
// Byte memory for match sequences and received strings
`timescale 1ns/1ps
`default_nettype none
module byte_store (
   input  wire logic       clock,
   input  wire logic       we,
   input  wire logic [4:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [4:0] raddr,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:31];
   logic [7:0] rdata_r;

   always_ff @(posedge clock) begin
      if (we)
         mem[waddr] <= wdata;
      rdata_r <= mem[raddr];
   end

   assign rdata = rdata_r;
endmodule // byte_store
`default_nettype wire

/* logic/async_serial_receiver.sv */
// Asynchronous serial receiver with Avalon-MM register access
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_consts.svh"

module async_serial_receiver
   import serial_rx_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rxDataPin,
   output logic             rxDataOe,
   output logic             flowCtrlPinOut,
   output logic             flowCtrlPinOe
);
   logic [31:0]  ctrl_r;
   logic [15:0]  mode_r;
   logic [15:0]  tmo_r;
   logic [24:0]  item_r;
   logic [1:0]   busStage_r;
   logic         waitReq_r;
   logic [31:0]  rdData_r;
   cmd_state_t   cst_r;
   frame_state_t fst_r;
   logic [13:0]  bitTmr_r;
   logic [3:0]   bitIdx_r;
   logic [8:0]   shift_r;
   logic         rxValid_r;
   logic         frmErr_r;
   logic [7:0]   usCnt_r;
   logic         usTick_r;
   logic [9:0]   msUs_r;
   logic [15:0]  tmoMs_r;
   logic [3:0]   qIdx_r;
   logic [15:0]  value_r;
   logic [7:0]   digCnt_r;
   logic         gotDigit_r;
   logic [4:0]   strLen_r;
   logic [3:0]   st_r;
   logic         rxOe_r;
   logic         flowOe_r;
   logic         flowOut_r;
   logic [7:0]   memRd;

   function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
      regHit = (a == off);
   endfunction

   function automatic logic [12:0] presetField(input logic [1:0] p);
      unique case (p)
         2'h0: presetField = `BT_2400;
         2'h1: presetField = `BT_1200;
         2'h2: presetField = `BT_9600;
         2'h3: presetField = `BT_300;
      endcase
   endfunction

   function automatic logic [3:0] dataBitsOf(input logic ext, input logic par,
                                             input logic [3:0] cb);
      logic [3:0] c;
      c = (cb < `CHAR_BITS_MIN) ? `CHAR_BITS_MIN : cb;
      c = (c > `CHAR_BITS_MAX) ? `CHAR_BITS_MAX : c;
      if (!ext)
         dataBitsOf = `DATA_BITS_MAX;
      else if (par)
         dataBitsOf = (c < `CHAR_BITS_PAR) ? `CHAR_BITS_MIN : c - 4'h1;
      else
         dataBitsOf = (c > `DATA_BITS_MAX) ? `DATA_BITS_MAX : c;
   endfunction

   function automatic logic [4:0] digitVal(input item_kind_t k, input logic [7:0] b);
      logic [4:0] r;
      r = 5'h00;
      if (b >= `ASC_0 && b <= `ASC_9)
         r = {1'b1, b[3:0]};
      else if (k == ITEM_HEX && ((b >= `ASC_UA && b <= `ASC_UF) ||
                                 (b >= `ASC_LA && b <= `ASC_LF)))
         r = {1'b1, 4'(b[3:0] + `HEX_LETTER_BIAS)};
      if (k == ITEM_BIN && b != `ASC_0 && b != `ASC_1)
         r = 5'h00;
      digitVal = r;
   endfunction

   function automatic logic [15:0] radixOf(input item_kind_t k);
      unique case (k)
         ITEM_BIN: radixOf = 16'h0002;
         ITEM_HEX: radixOf = 16'h0010;
         default:  radixOf = 16'h000A;
      endcase
   endfunction

   // Configuration decode
   logic        busy;
   logic        wrAcc;
   logic        cfgWr;
   logic        startCmd;
   logic        ext;
   logic        inv;
   logic        parEn;
   logic [12:0] bitField;
   logic [13:0] periodUs;
   logic [3:0]  dataBits;
   logic [3:0]  nBits;
   logic [7:0]  dataMask;
   logic [7:0]  rxByte;
   logic        line;
   item_kind_t  kind;
   logic [3:0]  qLen;
   logic [7:0]  itemCnt;
   logic [7:0]  usLim;

   assign busy     = (cst_r != C_IDLE);
   assign wrAcc    = avs_write && !waitReq_r;
   assign cfgWr    = wrAcc && !busy;
   assign startCmd = cfgWr && regHit(avs_address, `OFF_CTRL) && avs_writedata[`CTL_START];
   assign ext      = ctrl_r[`CTL_EXT];
   assign inv      = ext ? mode_r[`MODE_INV] : ctrl_r[`CTL_PRESET_LSB + 2];
   assign parEn    = ext && mode_r[`MODE_PAR];
   assign bitField = ext ? mode_r[12:0] : presetField(ctrl_r[`CTL_PRESET_LSB +: 2]);
   assign periodUs = {1'b0, bitField} + `BIT_OFFSET_US;
   assign dataBits = dataBitsOf(ext, parEn, ctrl_r[`CTL_BITS_LSB +: 4]);
   assign nBits    = dataBits + {3'h0, parEn};
   assign dataMask = 8'hFF >> (`DATA_BITS_MAX - dataBits);
   assign rxByte   = shift_r[7:0] & dataMask;
   assign line     = rxDataPin ^ inv;
   assign kind     = item_kind_t'(item_r[2:0]);
   assign qLen     = item_r[`ITM_QLEN_LSB +: 4];
   assign itemCnt  = item_r[`ITM_CNT_LSB +: 8];
   assign usLim    = (ctrl_r[`CTL_MHZ_LSB +: 8] == 8'h00) ? 8'h00 :
                     ctrl_r[`CTL_MHZ_LSB +: 8] - 8'h01;

   // Byte processing decisions
   logic        parBad;
   logic        parAbort;
   logic        tmoAbort;
   logic        accept;
   logic [4:0]  dig;
   logic        termHit;
   logic        strWr;
   logic        itemDone;
   logic [15:0] value_nxt;
   logic [7:0]  cntInc;

   always_comb begin
      parBad    = parEn && (^shift_r);
      parAbort  = rxValid_r && busy && parBad && ctrl_r[`CTL_PAR_EXIT];
      tmoAbort  = busy && ctrl_r[`CTL_TMO_EN] && !rxValid_r && (tmoMs_r == tmo_r);
      accept    = rxValid_r && busy && !parAbort;
      dig       = digitVal(kind, rxByte);
      termHit   = item_r[`ITM_TERM_EN] && (rxByte == item_r[`ITM_TERM_LSB +: 8]);
      strWr     = accept && cst_r == C_ITEM && kind == ITEM_STR && !termHit;
      cntInc    = digCnt_r + 8'h01;
      value_nxt = value_r * radixOf(kind) + {12'h000, dig[3:0]};
      unique case (kind)
         ITEM_DEC, ITEM_BIN, ITEM_HEX:
            itemDone = dig[4] ? (itemCnt != 8'h00 && cntInc == itemCnt) : gotDigit_r;
         ITEM_SKIP: itemDone = (cntInc >= itemCnt);
         ITEM_STR:  itemDone = termHit || (strLen_r + 5'h01 >= {1'b0, itemCnt[4:0]}) ||
                               (itemCnt > 8'h10) && (strLen_r == `STR_LAST);
         default:   itemDone = 1'b1;
      endcase
   end

   // Register bus slave: every access answers two cycles after it appears
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      if (avs_address[`BUF_SEL_BIT])
         rdMux = {24'h00_0000, memRd};
      else if (regHit(avs_address, `OFF_CTRL))
         rdMux = ctrl_r;
      else if (regHit(avs_address, `OFF_MODE))
         rdMux = {16'h0000, mode_r};
      else if (regHit(avs_address, `OFF_TIMEOUT))
         rdMux = {16'h0000, tmo_r};
      else if (regHit(avs_address, `OFF_ITEM))
         rdMux = {7'h00, item_r};
      else if (regHit(avs_address, `OFF_STATUS))
         rdMux = {27'h000_0000, st_r, busy};
      else if (regHit(avs_address, `OFF_RESULT))
         rdMux = {11'h000, strLen_r, value_r};
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         busStage_r <= 2'h0;
         waitReq_r  <= 1'b1;
         rdData_r   <= 32'h0000_0000;
      end else if (!waitReq_r) begin
         waitReq_r  <= 1'b1;
         busStage_r <= 2'h0;
      end else if (avs_read || avs_write) begin
         if (busStage_r == `BUS_LAT) begin
            waitReq_r <= 1'b0;
            if (avs_read)
               rdData_r <= rdMux;
         end else begin
            busStage_r <= busStage_r + 2'h1;
         end
      end
   end

   assign avs_waitrequest = waitReq_r;
   assign avs_readdata    = rdData_r;

   // Configuration registers, held while a command runs
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_r <= `CTRL_RST;
         mode_r <= 16'h0000;
         tmo_r  <= 16'h0000;
         item_r <= 25'h000_0000;
      end else if (cfgWr) begin
         if (regHit(avs_address, `OFF_CTRL))
            ctrl_r <= avs_writedata & `CTRL_WR_MASK;
         if (regHit(avs_address, `OFF_MODE))
            mode_r <= avs_writedata[15:0];
         if (regHit(avs_address, `OFF_TIMEOUT))
            tmo_r <= avs_writedata[15:0];
         if (regHit(avs_address, `OFF_ITEM))
            item_r <= avs_writedata[24:0];
      end
   end

   // Match and string buffer
   logic       memWe;
   logic [4:0] memWaddr;
   logic [4:0] memRaddr;
   logic [7:0] memWdata;

   // Bus reads of the buffer borrow the port; bytes arrive far apart, so qualifiers are back
   assign memRaddr = (avs_read && avs_address[`BUF_SEL_BIT]) ? avs_address[6:2] :
                     {1'b0, qIdx_r};
   assign memWe    = (cfgWr && avs_address[`BUF_SEL_BIT]) || strWr;
   assign memWaddr = strWr ? {1'b1, strLen_r[3:0]} : avs_address[6:2];
   assign memWdata = strWr ? rxByte : avs_writedata[7:0];

   byte_store u_store (
      .clock (clock),
      .we    (memWe),
      .waddr (memWaddr),
      .wdata (memWdata),
      .raddr (memRaddr),
      .rdata (memRd)
   );

   // Microsecond enable from the core clock setting, millisecond timeout count
   always_ff @(posedge clock) begin
      usTick_r <= 1'b0;
      if (!rstn) begin
         usCnt_r <= 8'h00;
      end else if (usCnt_r >= usLim) begin
         usCnt_r  <= 8'h00;
         usTick_r <= 1'b1;
      end else begin
         usCnt_r <= usCnt_r + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || startCmd || rxValid_r) begin
         msUs_r  <= 10'h000;
         tmoMs_r <= 16'h0000;
      end else if (usTick_r) begin
         if (msUs_r == 10'(`TMO_UNIT_US - 1)) begin
            msUs_r <= 10'h000;
            if (tmoMs_r != 16'hFFFF)
               tmoMs_r <= tmoMs_r + 16'h0001;
         end else begin
            msUs_r <= msUs_r + 10'h001;
         end
      end
   end

   // Character framing
   always_ff @(posedge clock) begin
      rxValid_r <= 1'b0;
      frmErr_r  <= 1'b0;
      if (!rstn) begin
         fst_r    <= F_IDLE;
         bitTmr_r <= 14'h0000;
         bitIdx_r <= 4'h0;
         shift_r  <= 9'h000;
      end else if (!busy) begin
         fst_r <= F_IDLE;
      end else begin
         unique case (fst_r)
            F_IDLE: if (!line) begin
               fst_r    <= F_START;
               bitTmr_r <= periodUs >> 1;
               shift_r  <= 9'h000;
            end
            F_START: if (usTick_r) begin
               if (bitTmr_r != 14'h0000)
                  bitTmr_r <= bitTmr_r - 14'h0001;
               else if (line)
                  fst_r <= F_IDLE;
               else begin
                  fst_r    <= F_BITS;
                  bitTmr_r <= periodUs - 14'h0001;
                  bitIdx_r <= 4'h0;
               end
            end
            F_BITS: if (usTick_r) begin
               if (bitTmr_r != 14'h0000)
                  bitTmr_r <= bitTmr_r - 14'h0001;
               else begin
                  shift_r[bitIdx_r] <= line;
                  bitTmr_r          <= periodUs - 14'h0001;
                  if (bitIdx_r == nBits - 4'h1)
                     fst_r <= F_STOP;
                  else
                     bitIdx_r <= bitIdx_r + 4'h1;
               end
            end
            F_STOP: if (usTick_r) begin
               if (bitTmr_r != 14'h0000)
                  bitTmr_r <= bitTmr_r - 14'h0001;
               else begin
                  fst_r <= F_IDLE;
                  if (line)
                     rxValid_r <= 1'b1;
                  else
                     frmErr_r <= 1'b1;
               end
            end
         endcase
      end
   end

   // Command sequencing: match sequence first, then the item
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cst_r      <= C_IDLE;
         qIdx_r     <= 4'h0;
         value_r    <= 16'h0000;
         digCnt_r   <= 8'h00;
         gotDigit_r <= 1'b0;
         strLen_r   <= 5'h00;
      end else if (startCmd) begin
         cst_r      <= (qLen != 4'h0) ? C_QUAL : C_ITEM;
         qIdx_r     <= 4'h0;
         value_r    <= 16'h0000;
         digCnt_r   <= 8'h00;
         gotDigit_r <= 1'b0;
         strLen_r   <= 5'h00;
      end else if (tmoAbort || parAbort) begin
         cst_r <= C_IDLE;
      end else if (accept) begin
         unique case (cst_r)
            C_IDLE: ;
            C_QUAL: begin
               if (rxByte != memRd)
                  qIdx_r <= 4'h0;
               else if (qIdx_r == qLen - 4'h1)
                  cst_r <= C_ITEM;
               else
                  qIdx_r <= qIdx_r + 4'h1;
            end
            C_ITEM: begin
               if (kind == ITEM_RAW)
                  value_r <= {8'h00, rxByte};
               if ((kind == ITEM_DEC || kind == ITEM_BIN || kind == ITEM_HEX) && dig[4]) begin
                  value_r    <= value_nxt;
                  gotDigit_r <= 1'b1;
                  digCnt_r   <= cntInc;
               end
               if (kind == ITEM_SKIP)
                  digCnt_r <= cntInc;
               if (strWr)
                  strLen_r <= strLen_r + 5'h01;
               if (itemDone)
                  cst_r <= C_IDLE;
            end
         endcase
      end
   end

   // Sticky status: a hardware event wins over a same-cycle clear
   logic [3:0] stSet;
   logic [3:0] stClr;
   assign stSet = {frmErr_r && busy, rxValid_r && busy && parBad, tmoAbort,
                   accept && cst_r == C_ITEM && itemDone};
   assign stClr = startCmd ? 4'hF :
                  (wrAcc && regHit(avs_address, `OFF_STATUS)) ? avs_writedata[4:1] : 4'h0;

   always_ff @(posedge clock) begin
      if (!rstn)
         st_r <= 4'h0;
      else
         st_r <= (st_r & ~stClr) | stSet;
   end

   // Pin directions and flow level
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rxOe_r    <= 1'b0;
         flowOe_r  <= 1'b0;
         flowOut_r <= 1'b0;
      end else begin
         if (startCmd)
            rxOe_r <= 1'b0;
         else if (cfgWr && regHit(avs_address, `OFF_CTRL))
            rxOe_r <= avs_writedata[`CTL_DRIVE];
         flowOe_r  <= busy && ext && ctrl_r[`CTL_FLOW];
         flowOut_r <= (busy && fst_r == F_IDLE) ? ~inv : inv;
      end
   end

   assign rxDataOe       = rxOe_r;
   assign flowCtrlPinOut = flowOut_r;
   assign flowCtrlPinOe  = flowOe_r;
endmodule // async_serial_receiver
`default_nettype wire

/* sim/async_serial_receiver_assertions.sv */
// Concurrent checks on the serial receiver's bus answers and pin behaviour
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_consts.svh"
module async_serial_receiver_assertions (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        rxDataPin,
   input wire logic        rxDataOe,
   input wire logic        flowCtrlPinOut,
   input wire logic        flowCtrlPinOe
);
   logic modeInv_r;
   logic ctlWr;
   logic drvWr;
   logic flowOn;
   assign ctlWr  = avs_write && !avs_waitrequest && avs_address == `OFF_CTRL;
   assign drvWr  = ctlWr && avs_writedata[`CTL_DRIVE];
   assign flowOn = flowCtrlPinOut ^ modeInv_r;
   // Shadow of the inversion bit; the bench only writes mode while idle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         modeInv_r <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_address == `OFF_MODE) begin
         modeInv_r <= avs_writedata[`MODE_INV];
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   sequence reqStart;
      (avs_read || avs_write) && !$past(avs_read || avs_write);
   endsequence
   sequence ackInTwo;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   chk_ack_cycle: assert property (reqStart |-> ##1 ackInTwo)
      else $error("bus answer not in cycle 2");
   chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer longer than one cycle");
   chk_ack_cause: assert property (!avs_waitrequest |->
      (avs_read || avs_write) && $past(avs_read || avs_write, 2))
      else $error("bus answer without request");
   chk_rdata_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
      else $error("read data changed outside a read answer");
   chk_pin_dir: assert property (flowCtrlPinOe |-> !rxDataOe)
      else $error("data pin driven while flow pin driven");
   chk_start_input: assert property (ctlWr && avs_writedata[`CTL_START] |-> ##[1:2] !rxDataOe)
      else $error("data pin not input after start");
   chk_drive_cause: assert property ($rose(rxDataOe) |-> $past(drvWr) || $past(drvWr, 2))
      else $error("data pin drive without request");
   chk_flow_first: assert property ($rose(flowCtrlPinOe) |-> ##[0:2] flowOn)
      else $error("flow pin not enabled at command start");
   chk_flow_drop: assert property (flowCtrlPinOe && flowOn && !(rxDataPin ^ modeInv_r)
      |-> ##[1:6] !flowOn)
      else $error("flow pin not disabled at start edge");
   chk_flow_hold: assert property (flowCtrlPinOe && $fell(flowOn) |-> (!flowOn)[*8])
      else $error("flow pin re-enabled within a frame");
endmodule // async_serial_receiver_assertions
`default_nettype wire

/* sim/serial_tx_model.sv */
// Behavioural asynchronous serial transmitter driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
   input  wire logic clock,
   input  wire logic flowOut,
   input  wire logic flowOe,
   output var logic  line
);
   int   per = 104;
   int   nd = 8;
   logic inv = 1'b0;
   logic par = 1'b0;
   logic flow = 1'b0;
   logic badPar = 1'b0;
   logic stalled = 1'b0;
   initial line = 1'b1;
   task automatic idle();
      line <= !inv;
   endtask
   task automatic bitOut(input logic b);
      line <= b ^ inv;
      repeat (per) @(posedge clock);
   endtask
   task automatic sendChar(input logic [7:0] c);
      int k;
      k = 0;
      // Hold the character back until the receiver shows the enabled level
      while (flow && !(flowOe && flowOut == !inv) && k < 20000) begin
         @(posedge clock);
         k++;
      end
      if (k >= 20000) stalled = 1'b1;
      bitOut(1'b0);
      for (int i = 0; i < nd; i++) bitOut(c[i]);
      if (par) bitOut(^(c & (8'hFF >> (8 - nd))) ^ badPar);
      bitOut(1'b1);
   endtask
endmodule // serial_tx_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_consts.svh"
module tb;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   wire logic   rxDataPin;
   logic        rxDataOe;
   logic        flowCtrlPinOut;
   logic        flowCtrlPinOe;
   int          fails = 0;
   int          n_checks = 0;
   logic [31:0] q;
   always #2 clock = ~clock;
   async_serial_receiver dut_u (.clock(clock), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rxDataPin(rxDataPin), .rxDataOe(rxDataOe), .flowCtrlPinOut(flowCtrlPinOut),
      .flowCtrlPinOe(flowCtrlPinOe));
   serial_tx_model txm (.clock(clock), .flowOut(flowCtrlPinOut), .flowOe(flowCtrlPinOe),
      .line(rxDataPin));
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang();
      fails++;
      $display("Error at %0t: wait timed out", $time);
      end_sim();
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
      if (k >= 20) hang();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic waitIdle();
      int k;
      for (k = 0; k < 3000; k++) begin
         rd(`OFF_STATUS);
         if (q[0] === 1'b0) break;
      end
      if (k == 3000) hang();
   endtask
   task automatic cfg(input int per, input logic inv, input int nd, input logic par,
                      input logic fl);
      txm.per = per;
      txm.inv = inv;
      txm.nd = nd;
      txm.par = par;
      txm.flow = fl;
      txm.idle();
   endtask
   // Core clock set to 1 MHz so one microsecond is one cycle
   task automatic run(input logic [31:0] ctl, input logic [15:0] mode, input logic [31:0] item,
                      input string s);
      wr(`OFF_CTRL, 32'h0100_1000);
      chk(32'(rxDataOe), 32'h1);
      wr(`OFF_MODE, {16'h0, mode});
      wr(`OFF_ITEM, item);
      wr(`OFF_CTRL, ctl | 32'h0100_0001);
      chk(32'(rxDataOe), 32'h0);
      for (int i = 0; i < s.len(); i++) txm.sendChar(s[i]);
      if (txm.stalled) hang();
      waitIdle();
   endtask
   task automatic t_regs();
      rd(`OFF_CTRL);
      chk(q, `CTRL_RST);
      rd(`OFF_STATUS);
      chk(q, 32'h0);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20);
      chk(q, 32'h0);
      wr(`OFF_CTRL, 32'hFFFF_FFFE);
      rd(`OFF_CTRL);
      chk(q, `CTRL_WR_MASK);
   endtask
   task automatic t_presets();
      int baud [4] = '{2400, 1200, 9600, 300};
      string s = " ";
      for (int p = 0; p < 8; p++) begin
         // Slowest true-polarity rate left out to bound the run length
         if (p == 3) continue;
         s.putc(0, 8'hA5 ^ 8'(p));
         cfg(1000000 / baud[p % 4], p >= 4, 8, 1'b0, 1'b0);
         run(32'(p) << 5, 16'h0, 32'h0, s);
         rd(`OFF_RESULT);
         chk(q & 32'hFFFF, {24'h0, 8'hA5 ^ 8'(p)});
      end
   endtask
   task automatic t_qual();
      cfg(104, 1'b0, 8, 1'b0, 1'b0);
      wr(8'h80, 32'h41);
      wr(8'h84, 32'h42);
      run(32'h40, 16'h0, 32'h20, "AABABZ");
      rd(`OFF_RESULT);
      chk(q & 32'hFFFF, 32'h5A);
   endtask
   task automatic t_parity();
      cfg(104, 1'b1, 7, 1'b1, 1'b1);
      txm.badPar = 1'b1;
      run(32'h80E, 16'hE054, 32'h0, "c");
      rd(`OFF_STATUS);
      chk(q & 32'h9, 32'h8);
      txm.badPar = 1'b0;
      run(32'h80E, 16'hE054, 32'h0, "5");
      rd(`OFF_RESULT);
      chk(q & 32'hFFFF, 32'h35);
   endtask
   task automatic t_digits();
      string s [4] = '{"x12;", "zFE.", "1000 ", "9876"};
      logic [31:0] it [4] = '{32'h1, 32'h3, 32'h2, 32'h401};
      logic [15:0] ex [4] = '{16'd12, 16'd254, 16'd8, 16'd9876};
      cfg(104, 1'b0, 8, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         run(32'h802, 16'h0054, it[i], s[i]);
         rd(`OFF_RESULT);
         chk(q & 32'hFFFF, {16'h0, ex[i]});
      end
   endtask
   task automatic t_misc();
      cfg(104, 1'b0, 5, 1'b0, 1'b0);
      run(32'h502, 16'h0054, 32'h0, "5");
      rd(`OFF_RESULT);
      chk(q & 32'hFFFF, 32'h15);
      cfg(104, 1'b0, 8, 1'b1, 1'b0);
      run(32'h902, 16'h2054, 32'h0, "\303");
      rd(`OFF_RESULT);
      chk(q & 32'hFFFF, 32'hC3);
      cfg(104, 1'b0, 8, 1'b0, 1'b0);
      // One character at this rate spans more than 1 ms
      wr(`OFF_TIMEOUT, 32'h2);
      run(32'h812, 16'h0054, 32'h304, "abc");
      rd(`OFF_STATUS);
      chk(q & 32'h7, 32'h2);
      run(32'h812, 16'h0054, 32'h304, "ab");
      rd(`OFF_STATUS);
      chk(q & 32'h7, 32'h4);
      run(32'h802, 16'h0054, 32'h0123_0505, "hi#");
      rd(8'hC0);
      chk(q, 32'h68);
      rd(8'hC4);
      chk(q, 32'h69);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_regs();
      t_presets();
      t_qual();
      t_parity();
      t_digits();
      t_misc();
      end_sim();
   end
endmodule // tb
bind async_serial_receiver async_serial_receiver_assertions chk_u (.clock(clock), .rstn(rstn),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rxDataPin(rxDataPin), .rxDataOe(rxDataOe),
   .flowCtrlPinOut(flowCtrlPinOut), .flowCtrlPinOe(flowCtrlPinOe));
`default_nettype wire
